// file: rtl/lpwc_cfg.svh
`ifndef LPWC_CFG_SVH
`define LPWC_CFG_SVH
// Register indices; byte address is four times the index
`define LPWC_IDX_CLOCK_MODE_CONTROL 10'h0fd
`define LPWC_IDX_WAKECFG 10'h000
`define LPWC_IDX_WAKEEXT 10'h001
`define LPWC_IDX_PMODE 10'h002
`define LPWC_IDX_STATUS 10'h003
// Field positions
`define LPWC_B_LOW_POWER_GATING_ENABLE 2
`define LPWC_B_SLEEP 7
`define LPWC_B_SUSPEND 6
`define LPWC_B_CLEAR 5
`define LPWC_B_PINWK 4
`define LPWC_B_BATWK 2
`define LPWC_B_PCWK 0
`define LPWC_B_WAKE_REQUEST_OUT_ENABLE 6
`define LPWC_B_SUPPLY_MONITOR_DISABLE 5
// Reset values
`define LPWC_RST_CLOCK_MODE_CONTROL 8'h00
`define LPWC_RST_PMODE 8'h00
// Timing
`define LPWC_CLK_NS 25
`define LPWC_PIN_HOLD_NS 15000
`define LPWC_SETTLE_CYC 2
`define LPWC_WAKEREQ_CYC 8
`endif

// file: rtl/lpwc_pkg.sv
package lpwc_pkg;
  // Wake sources: 0 cmp, 1 port match, 2 rtc alarm, 3 rtc fail,
  // 4 pulse counter, 5 battery monitor
  typedef struct packed {
    logic bat_mon;
    logic pulse_cnt;
    logic rtc_fail;
    logic rtc_alarm;
    logic port_match;
    logic cmp_rise;
  } lpwc_ev_type;
  typedef struct packed {
    logic sys_clk_en;
    logic osc_en;
    logic core_reg_en;
    logic ram_on_bat;
    logic gpio_hold;
    logic cpu_clk_en;
    logic lp_active;
    logic mon_en;
  } lpwc_ctl_type;
  typedef enum logic [3:0] {
    LPWC_RUN = 4'h1,
    LPWC_SUSP = 4'h2,
    LPWC_SLEEP = 4'h4,
    LPWC_WAKE = 4'h8
  } lpwc_state_type;
endpackage

// file: rtl/lpwc_top.sv
// How it works
// - Low-power active or idle only while the gating enable bit is set.
// - Clock mode bits 7:3 and 1:0 read zero; software writes zeros.
// - Suspend gates the system clock and stops every oscillator.
// - While suspended everything stays halted until an enabled wake fires or the reset pin falls.
// - Six selectable wake sources for suspend and sleep.
// - After suspend wake, flags read zero for two clocks.
// - A reset-pin falling edge that stays low for two clocks leaves suspend or sleep.
// - Sleep turns the core regulator off and moves RAM to battery.
// - Digital output pins hold their level during sleep.
// - Digital input pins still wake through port match in sleep.
// - Leaving sleep drives the wake-request output low.
// - RAM, registers and state are kept through sleep.
// - Monitor disable bit; any reset then gives a full power-on reset.
// - Writing one to a source enable arms it.
// - Reset pin always wakes; device stays awake over 15 us.
// - Flags always set on events, enabled or not.
// - No entry while an enabled flag is set.
// - Clear bit clears all wake flags at once.
// - Suspend select bit places the device in suspend.
// - Gating enable plus idle gates the processor clock.
// - Wake request reaches its pin only when its enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "lpwc_cfg.svh"
module lpwc_top #(
  parameter int HOLD_CYC = (`LPWC_PIN_HOLD_NS + `LPWC_CLK_NS - 1) /
    `LPWC_CLK_NS + 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake events and system status
  input wire lpwc_pkg::lpwc_ev_type wake_ev,
  input wire logic rst_pin_n,
  input wire logic cpu_idle_req,
  input wire logic any_reset_ev,
  // Power control
  output lpwc_pkg::lpwc_ctl_type pwr_ctl,
  output logic full_por_req,
  // Wake request pin
  output logic wake_req_o,
  output logic wake_req_oe
);
  // ==========================================================
  // Declarations
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  lpwc_pkg::lpwc_state_type state_r;
  logic low_power_gating_enable_r, wake_oe_r, supply_monitor_disable_r, refused_r, pin_flag_r;
  logic [5:0] en_r, flag_r;
  logic [1:0] settle_r;
  logic [3:0] wreq_cnt_r;
  logic [HOLD_W-1:0] hold_r;
  logic [2:0] pin_sync_r;
  logic pin_stable_r, pin_fall;
  logic wr, rd_setup, mapped, low_req, entry_ok, wake_hit;
  logic [9:0] idx;
  logic [7:0] wdat;

  // Flags as seen by software: zero while settling
  function automatic logic [7:0] rd_mux(input logic [9:0] i);
    logic [5:0] f;
    f = (state_r == lpwc_pkg::LPWC_WAKE) ? 6'h00 : flag_r;
    if (i == `LPWC_IDX_CLOCK_MODE_CONTROL) begin
      rd_mux = 8'(low_power_gating_enable_r) << `LPWC_B_LOW_POWER_GATING_ENABLE;
    end else if (i == `LPWC_IDX_WAKECFG) begin
      rd_mux = {3'h0, pin_flag_r && state_r != lpwc_pkg::LPWC_WAKE, f[3:0]};
    end else if (i == `LPWC_IDX_WAKEEXT) begin
      rd_mux = {5'h00, f[5], 1'b0, f[4]};
    end else if (i == `LPWC_IDX_PMODE) begin
      rd_mux = {1'b0, wake_oe_r, supply_monitor_disable_r, 5'h00};
    end else if (i == `LPWC_IDX_STATUS) begin
      rd_mux = {3'h0, refused_r, state_r};
    end else begin
      rd_mux = 8'h00;
    end
  endfunction

  function automatic logic is_mapped(input logic [9:0] i);
    is_mapped = (i == `LPWC_IDX_CLOCK_MODE_CONTROL) || (i == `LPWC_IDX_WAKECFG) ||
      (i == `LPWC_IDX_WAKEEXT) || (i == `LPWC_IDX_PMODE) ||
      (i == `LPWC_IDX_STATUS);
  endfunction

  // ==========================================================
  // APB slave: no wait cycle; read data is registered from a flop in the setup cycle
  assign idx = paddr[11:2];
  assign wdat = pwdata[7:0];
  assign mapped = is_mapped(idx);
  assign rd_setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      prdata <= rd_setup ? {24'h00_0000, rd_mux(idx)} : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Reset pin: three flops, change counts when two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'h7;
      pin_stable_r <= 1'b1;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], rst_pin_n};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_stable_r <= pin_sync_r[2];
    end
  end
  // Short glitches count only once flops two and three of the synchroniser agree low
  assign pin_fall = pin_stable_r && !pin_sync_r[2] && !pin_sync_r[1];

  // ==========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_gating_enable_r <= 1'(`LPWC_RST_CLOCK_MODE_CONTROL >> `LPWC_B_LOW_POWER_GATING_ENABLE);
      wake_oe_r <= 1'b0;
      supply_monitor_disable_r <= 1'b0;
    end else begin
      if (wr && idx == `LPWC_IDX_CLOCK_MODE_CONTROL)
        low_power_gating_enable_r <= wdat[`LPWC_B_LOW_POWER_GATING_ENABLE];
      if (wr && idx == `LPWC_IDX_PMODE) begin
        wake_oe_r <= wdat[`LPWC_B_WAKE_REQUEST_OUT_ENABLE];
        if (wdat[`LPWC_B_SUPPLY_MONITOR_DISABLE])
          supply_monitor_disable_r <= 1'b1;
      end else if (any_reset_ev && supply_monitor_disable_r) begin
        supply_monitor_disable_r <= 1'b0;
      end
    end
  end

  // Full power-on reset request while the monitor is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      full_por_req <= 1'b0;
    else
      full_por_req <= any_reset_ev && supply_monitor_disable_r;
  end

  // ==========================================================
  // Wake flags: set on any event, set wins over the clear bit
  assign low_req = wr && idx == `LPWC_IDX_WAKECFG &&
    (wdat[`LPWC_B_SLEEP] || wdat[`LPWC_B_SUSPEND]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 6'h00;
      pin_flag_r <= 1'b0;
    end else begin
      if (wr && idx == `LPWC_IDX_WAKECFG && wdat[`LPWC_B_CLEAR])
        flag_r <= wake_ev;
      else
        flag_r <= flag_r | wake_ev;
      if (pin_fall)
        pin_flag_r <= 1'b1;
      else if (wr && idx == `LPWC_IDX_WAKECFG && wdat[`LPWC_B_CLEAR])
        pin_flag_r <= 1'b0;
    end
  end

  // Enables 3:0 come from the write that requests the mode; 5:4 from the extension register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 6'h00;
    end else if (wr && idx == `LPWC_IDX_WAKECFG) begin
      en_r[3:0] <= wdat[3:0];
    end else if (wr && idx == `LPWC_IDX_WAKEEXT) begin
      en_r[5] <= wdat[`LPWC_B_BATWK];
      en_r[4] <= wdat[`LPWC_B_PCWK];
    end else if (state_r == lpwc_pkg::LPWC_WAKE) begin
      en_r <= 6'h00; // Sources must be armed again each entry
    end
  end

  // Entry check uses enables 3:0 of this same write and the stored enables 5:4
  logic [5:0] new_en;
  assign new_en = {en_r[5:4], wdat[3:0]};
  assign entry_ok = ((flag_r & new_en) == 6'h00) && !pin_flag_r &&
    hold_r == '0;
  assign wake_hit = ((flag_r | wake_ev) & en_r) != 6'h00 || pin_fall;

  // ==========================================================
  // Mode state machine on the always-on clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= lpwc_pkg::LPWC_RUN;
      settle_r <= 2'h0;
      refused_r <= 1'b0;
    end else begin
      case (state_r)
        lpwc_pkg::LPWC_RUN: begin
          if (low_req && !entry_ok) begin
            refused_r <= 1'b1;
          end else if (low_req && wdat[`LPWC_B_SLEEP]) begin
            state_r <= lpwc_pkg::LPWC_SLEEP;
            refused_r <= 1'b0;
          end else if (low_req) begin
            state_r <= lpwc_pkg::LPWC_SUSP;
            refused_r <= 1'b0;
          end
        end
        lpwc_pkg::LPWC_SUSP, lpwc_pkg::LPWC_SLEEP: begin
          if (wake_hit) begin
            state_r <= lpwc_pkg::LPWC_WAKE;
            settle_r <= 2'(`LPWC_SETTLE_CYC - 1);
          end
        end
        lpwc_pkg::LPWC_WAKE: begin
          if (settle_r == 2'h0)
            state_r <= lpwc_pkg::LPWC_RUN;
          else
            settle_r <= settle_r - 2'h1;
        end
        default: state_r <= lpwc_pkg::LPWC_RUN;
      endcase
    end
  end

  // Stay awake after a pin wake so the pin reset can act
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_r <= '0;
    else if (pin_fall)
      hold_r <= HOLD_W'(HOLD_CYC);
    else if (hold_r != '0)
      hold_r <= hold_r - HOLD_W'(1);
  end

  // ==========================================================
  // Wake request pin: low for a burst after leaving sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreq_cnt_r <= 4'h0;
      wake_req_o <= 1'b1;
      wake_req_oe <= 1'b0;
    end else begin
      if (state_r == lpwc_pkg::LPWC_SLEEP && wake_hit)
        wreq_cnt_r <= 4'(`LPWC_WAKEREQ_CYC);
      else if (wreq_cnt_r != 4'h0)
        wreq_cnt_r <= wreq_cnt_r - 4'h1;
      wake_req_o <= !(state_r == lpwc_pkg::LPWC_SLEEP && wake_hit) &&
        wreq_cnt_r <= 4'h1;
      wake_req_oe <= wake_oe_r;
    end
  end

  // ==========================================================
  // Power controls, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctl <= '{sys_clk_en: 1'b1, osc_en: 1'b1, core_reg_en: 1'b1,
        ram_on_bat: 1'b0, gpio_hold: 1'b0, cpu_clk_en: 1'b1,
        lp_active: 1'b0, mon_en: 1'b1};
    end else begin
      pwr_ctl.sys_clk_en <= state_r == lpwc_pkg::LPWC_RUN ||
        state_r == lpwc_pkg::LPWC_WAKE;
      pwr_ctl.osc_en <= state_r != lpwc_pkg::LPWC_SUSP &&
        state_r != lpwc_pkg::LPWC_SLEEP;
      pwr_ctl.core_reg_en <= state_r != lpwc_pkg::LPWC_SLEEP;
      pwr_ctl.ram_on_bat <= state_r == lpwc_pkg::LPWC_SLEEP;
      pwr_ctl.gpio_hold <= state_r == lpwc_pkg::LPWC_SLEEP;
      pwr_ctl.cpu_clk_en <= !(low_power_gating_enable_r && cpu_idle_req) &&
        state_r != lpwc_pkg::LPWC_SUSP &&
        state_r != lpwc_pkg::LPWC_SLEEP;
      pwr_ctl.lp_active <= low_power_gating_enable_r &&
        state_r == lpwc_pkg::LPWC_RUN;
      pwr_ctl.mon_en <= !supply_monitor_disable_r;
    end
  end

  // ==========================================================
  // Checks
  sequence s_low_write;
    low_req && state_r == lpwc_pkg::LPWC_RUN;
  endsequence
  sequence s_settle;
    state_r == lpwc_pkg::LPWC_WAKE [*2] ##1 state_r == lpwc_pkg::LPWC_RUN;
  endsequence

  AST_NO_ENTRY_FLAGGED: assert property (@(posedge pclk)
    disable iff (!presetn) s_low_write ##0 !entry_ok |=>
      state_r == lpwc_pkg::LPWC_RUN && refused_r)
    else $error("entered low power with an enabled flag set");
  AST_SUSP_ENTRY: assert property (@(posedge pclk)
    disable iff (!presetn) s_low_write ##0 entry_ok &&
      !wdat[`LPWC_B_SLEEP] |=> state_r == lpwc_pkg::LPWC_SUSP ##1
      !pwr_ctl.sys_clk_en && !pwr_ctl.osc_en)
    else $error("suspend did not gate clock and oscillators");
  AST_SLEEP_PWR: assert property (@(posedge pclk)
    disable iff (!presetn) state_r == lpwc_pkg::LPWC_SLEEP |=>
      !pwr_ctl.core_reg_en && pwr_ctl.ram_on_bat && pwr_ctl.gpio_hold)
    else $error("sleep power controls wrong");
  AST_SETTLE_TWO: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(state_r == lpwc_pkg::LPWC_WAKE) |->
      s_settle)
    else $error("wake settle not two clocks");
  AST_FLAGS_ZERO: assert property (@(posedge pclk)
    disable iff (!presetn) state_r == lpwc_pkg::LPWC_WAKE && rd_setup &&
      idx == `LPWC_IDX_WAKECFG |=> prdata[5:0] == 6'h00)
    else $error("flags visible during settle");
  AST_PIN_WAKE: assert property (@(posedge pclk)
    disable iff (!presetn) pin_fall && (state_r == lpwc_pkg::LPWC_SUSP ||
      state_r == lpwc_pkg::LPWC_SLEEP) |=> state_r == lpwc_pkg::LPWC_WAKE)
    else $error("pin edge did not wake");
  AST_PIN_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn) pin_fall |=> hold_r == HOLD_W'(HOLD_CYC) &&
      !entry_ok)
    else $error("re-entry not blocked after pin wake");
  AST_FLAG_SET: assert property (@(posedge pclk)
    disable iff (!presetn) wake_ev != 6'h00 |=>
      (flag_r & $past(wake_ev)) == $past(wake_ev))
    else $error("event lost from flags");
  AST_WAKE_REQ: assert property (@(posedge pclk)
    disable iff (!presetn) state_r == lpwc_pkg::LPWC_SLEEP && wake_hit
      |=> !wake_req_o [*8])
    else $error("wake request not driven low");
  AST_MON_POR: assert property (@(posedge pclk)
    disable iff (!presetn) any_reset_ev && supply_monitor_disable_r && !wr |=>
      full_por_req && !supply_monitor_disable_r ##1 pwr_ctl.mon_en)
    else $error("reset with monitor off did not force por");
  AST_LP_GATE: assert property (@(posedge pclk)
    disable iff (!presetn) !low_power_gating_enable_r |=> !pwr_ctl.lp_active)
    else $error("low power active without enable");
endmodule // lpwc_top
`default_nettype wire

// file: dv/lpwc_wake_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Wake event sources and the external wake pin
module lpwc_wake_src (
  // Clock
  input wire logic pclk,
  // Wake request from the device
  input wire logic wake_req_o,
  input wire logic wake_req_oe,
  // Toward the device, and the resolved wake pin back to the bench
  output lpwc_pkg::lpwc_ev_type wake_ev,
  output logic rst_pin_n,
  output logic wake_pin
);
  // Pull-up holds the pin high whenever the device is not driving it
  assign wake_pin = wake_req_oe ? wake_req_o : 1'b1;
  // Quiet sources and a released reset pin from time zero
  initial begin
    wake_ev = '0;
    rst_pin_n = 1'b1;
  end
  // One-cycle event pulse, launched just after an edge
  task automatic pulse(input logic [5:0] m);
    wake_ev <= m;
    @(posedge pclk);
    wake_ev <= '0;
  endtask
  // Short low glitch, too brief to reset the whole chip
  task automatic glitch(input int n);
    rst_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    rst_pin_n <= 1'b1;
  endtask
endmodule // lpwc_wake_src
`default_nettype wire

// file: dv/tb_low_power_mode_wake_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpwc_cfg.svh"
// ==================================================
// Bench acting as software over the register bus
module tb_low_power_mode_wake_control;
  // Short pin hold keeps the run brief
  localparam int HOLD = 40;
  localparam logic [11:0] A_CLK = {`LPWC_IDX_CLOCK_MODE_CONTROL, 2'b00};
  localparam logic [11:0] A_CFG = {`LPWC_IDX_WAKECFG, 2'b00};
  localparam logic [11:0] A_EXT = {`LPWC_IDX_WAKEEXT, 2'b00};
  localparam logic [11:0] A_MOD = {`LPWC_IDX_PMODE, 2'b00};
  localparam logic [11:0] A_STA = {`LPWC_IDX_STATUS, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cpu_idle_req, any_reset_ev, full_por_req, wake_req_o, wake_req_oe;
  logic rst_pin_n, wake_pin;
  logic por_seen = 1'b0;
  lpwc_pkg::lpwc_ev_type wake_ev;
  lpwc_pkg::lpwc_ctl_type pwr_ctl;
  int mismatches, compares;
  int low_cnt = 0;
  lpwc_top #(.HOLD_CYC(HOLD)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_ev(wake_ev), .rst_pin_n(rst_pin_n), .cpu_idle_req(cpu_idle_req),
    .any_reset_ev(any_reset_ev), .pwr_ctl(pwr_ctl),
    .full_por_req(full_por_req), .wake_req_o(wake_req_o),
    .wake_req_oe(wake_req_oe));
  lpwc_wake_src u_src (.pclk(pclk), .wake_req_o(wake_req_o),
    .wake_req_oe(wake_req_oe), .wake_ev(wake_ev), .rst_pin_n(rst_pin_n),
    .wake_pin(wake_pin));
  // ==================================================
  // Clock, monitors and helpers
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Pulses are one cycle long, so they are caught at every edge
  always @(posedge pclk) begin
    if (full_por_req === 1'b1) por_seen <= 1'b1;
    if (wake_pin === 1'b0) low_cnt <= low_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer, entered just after an edge; no cycle count assumed
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("BAD t=%0t no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Side-band levels from the core and the reset logic
  task automatic sys_in(input logic idle, input logic rev);
    cpu_idle_req <= idle;
    any_reset_ev <= rev;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // Poll the state until the device runs again, bounded
  task automatic wait_run;
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STA, 32'h0);
      n++;
    end while (rd[3:0] !== 4'h1 && n < 30);
    if (rd[3:0] !== 4'h1) begin
      mismatches++;
      $display("BAD t=%0t never back in run", $time);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well above the expected few hundred cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    $display("BAD t=%0t watchdog", $time);
    close_out();
  end
  // ==================================================
  // Test sequence
  initial begin
    logic [5:0] f;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sys_in(1'b0, 1'b0);
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({24'h0, pwr_ctl}, 32'he5);
    chk(32'(wake_req_oe), 32'h0);
    rchk(A_CLK, 8'h00);
    wr(A_CLK, 8'h04);
    rchk(A_CLK, 8'h04);
    chk(32'(pwr_ctl.lp_active), 32'h1);
    wr(A_STA, 8'hff);
    rchk(A_STA, 8'h01);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("registers done");
    sys_in(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    chk(32'(pwr_ctl.cpu_clk_en), 32'h0);
    wr(A_CLK, 8'h00);
    repeat (2) @(posedge pclk);
    chk(32'(pwr_ctl.cpu_clk_en), 32'h1);
    chk(32'(pwr_ctl.lp_active), 32'h0);
    sys_in(1'b0, 1'b0);
    wr(A_CLK, 8'h04);
    $display("gating done");
    u_src.pulse(6'h3f);
    rchk(A_CFG, 8'h0f);
    rchk(A_EXT, 8'h05);
    wr(A_CFG, 8'h20);
    rchk(A_CFG, 8'h00);
    rchk(A_EXT, 8'h00);
    $display("flags done");
    // Each source in turn; a disabled one must not wake the device
    // The bench clock already stands for an internal oscillator
    for (int i = 0; i < 6; i++) begin
      wr(A_CFG, 8'h20);
      if (i >= 4) wr(A_EXT, (i == 4) ? 8'h01 : 8'h04);
      wr(A_CFG, 8'h40 | ((i < 4) ? (8'h01 << i) : 8'h00));
      rchk(A_STA, 8'h02);
      chk(32'(pwr_ctl[7:6]), 32'h0);
      f = (6'h01 << i) | (6'h01 << ((i + 1) % 6));
      u_src.pulse(6'h01 << ((i + 1) % 6));
      rchk(A_STA, 8'h02);
      u_src.pulse(6'h01 << i);
      rchk(A_CFG, 8'h00);
      wait_run();
      rchk(A_STA, 8'h01);
      rchk(A_CFG, {4'h0, f[3:0]});
      rchk(A_EXT, {5'h0, f[5], 1'b0, f[4]});
    end
    $display("sources done");
    wr(A_CFG, 8'h20);
    u_src.pulse(6'h04);
    wr(A_CFG, 8'h41);
    rchk(A_STA, 8'h02);
    u_src.pulse(6'h01);
    wait_run();
    wr(A_CFG, 8'h20);
    wr(A_CFG, 8'h41);
    rchk(A_STA, 8'h02);
    u_src.pulse(6'h01);
    wait_run();
    wr(A_CFG, 8'h41);
    rchk(A_STA, 8'h11);
    $display("entry checks done");
    wr(A_CFG, 8'h20);
    wr(A_CFG, 8'h41);
    u_src.glitch(3);
    wait_run();
    rchk(A_CFG, 8'h10);
    wr(A_CFG, 8'h20);
    wr(A_CFG, 8'h41);
    rchk(A_STA, 8'h11);
    repeat (HOLD + 10) @(posedge pclk);
    wr(A_CFG, 8'h41);
    rchk(A_STA, 8'h02);
    u_src.pulse(6'h01);
    wait_run();
    $display("pin wake done");
    wr(A_MOD, 8'h40);
    @(posedge pclk);
    chk(32'(wake_req_oe), 32'h1);
    wr(A_CFG, 8'h20);
    wr(A_CFG, 8'h82);
    rchk(A_STA, 8'h04);
    chk(32'(pwr_ctl[5:3]), 32'h3);
    u_src.pulse(6'h02);
    wait_run();
    repeat (12) @(posedge pclk);
    chk(low_cnt, `LPWC_WAKEREQ_CYC);
    rchk(A_CLK, 8'h04);
    rchk(A_CFG, 8'h02);
    $display("sleep done");
    wr(A_MOD, 8'h60);
    repeat (2) @(posedge pclk);
    chk(32'(pwr_ctl.mon_en), 32'h0);
    sys_in(1'b0, 1'b1);
    @(posedge pclk);
    sys_in(1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    chk(32'(por_seen), 32'h1);
    chk(32'(pwr_ctl.mon_en), 32'h1);
    $display("monitor done");
    close_out();
  end
endmodule // tb_low_power_mode_wake_control
`default_nettype wire
